// ==== include/pdxe_pkg.sv ====
// constants for the protection and debug exception entry block
package pdxe_pkg;
    // machine state bit positions, bit 0 is msb
    localparam int MSR_EE_POS   = 31 - 16;
    localparam int MSR_ILE_POS  = 31 - 15;
    localparam int MSR_DCMP_POS = 31 - 21;
    localparam int MSR_ME_POS   = 31 - 19;
    localparam int MSR_IP_POS   = 31 - 25;
    localparam int MSR_IR_POS   = 31 - 26;
    localparam int MSR_DR_POS   = 31 - 27;
    localparam int MSR_LE_POS   = 31 - 31;
    // saved state and fault status bit positions
    localparam int SMS_GUARD_POS = 31 - 3;
    localparam int SMS_PROT_POS  = 31 - 4;
    localparam int DFS_PROT_POS  = 31 - 4;
    localparam int DFS_STORE_POS = 31 - 6;
    // saved state masks: low mask keeps bits 16:31 from machine state, debug mask marks old bits cleared
    localparam logic [31:0] SMS_LOW_MASK   = 32'h0000ffff;
    localparam logic [31:0] SMS_DBG_MASK   = 32'h783fffff;
    // vector bases and offsets
    localparam logic [31:0] VEC_BASE_LO    = 32'h00000000;
    localparam logic [31:0] VEC_BASE_HI    = 32'hfff00000;
    localparam logic [31:0] VEC_EMUL       = 32'h00001000;
    localparam logic [31:0] VEC_IPROT      = 32'h00001300;
    localparam logic [31:0] VEC_DPROT      = 32'h00001400;
    localparam logic [31:0] VEC_DBRK       = 32'h00001c00;
    localparam logic [31:0] VEC_IBRK       = 32'h00001d00;
    localparam logic [31:0] VEC_DEV_MASK   = 32'h00001e00;
    localparam logic [31:0] VEC_DEV_NMI    = 32'h00001f00;
    // register bus indices, byte address is index times four
    localparam logic [3:0] REG_SPC  = 4'h0;
    localparam logic [3:0] REG_SMS  = 4'h1;
    localparam logic [3:0] REG_DFS  = 4'h2;
    localparam logic [3:0] REG_DFA  = 4'h3;
    localparam logic [3:0] REG_BRKA = 4'h4;
    localparam logic [3:0] REG_MSR  = 4'h5;
    localparam logic [3:0] REG_CFG  = 4'h6;
    localparam logic [3:0] REG_VEC  = 4'h7;
    localparam int CFG_EN_COMP_POS  = 0;
    localparam int CFG_EXCEPTION_COMPRESSION_POS = 1;
    localparam logic [31:0] MSR_RESET = 32'h00000000;
    // entry states, none or take
    typedef enum logic [2:0]
    {
        PDXE_NONE = 3'h0,
        PDXE_TAKE = 3'h1
    } pdxe_state_t;
endpackage : pdxe_pkg

// ==== logic/pdxe_entry.sv ====
// protection, debug and emulation exception entry unit
`timescale 1ns/10ps
module pdxe_entry
    import pdxe_pkg::*;
(
    input  wire logic        clk,              // core clock
    input  wire logic        resetn,           // async reset, active low
    input  wire logic        fetch_valid,      // fetch reported this cycle
    input  wire logic        fetch_refused,    // protection unit refused
    input  wire logic        fetch_guarded,    // fetch to guarded storage
    input  wire logic [31:0] fetch_pc,         // faulting fetch address
    input  wire logic        data_valid,       // data access reported
    input  wire logic        data_refused,     // data protection refused
    input  wire logic        data_store,       // access is a store
    input  wire logic        data_first,       // first access of the insn
    input  wire logic [31:0] data_ea,          // data effective address
    input  wire logic [31:0] insn_pc,          // current instruction addr
    input  wire logic [31:0] next_pc,          // following instruction addr
    input  wire logic        ibrk_match,       // instruction breakpoint
    input  wire logic        lbrk_match,       // load/store breakpoint
    input  wire logic        periph_brk,       // peripheral breakpoint
    input  wire logic        devport_req,      // maskable port request
    input  wire logic        devport_nmi,      // non-maskable port request
    input  wire logic        unimpl_insn,      // unimplemented optional op
    input  wire logic        align_fault,      // alignment condition
    input  wire logic [3:0]  reg_addr,         // register index
    input  wire logic [31:0] reg_wdata,        // write data
    input  wire logic        reg_wr,           // write strobe
    input  wire logic        reg_rd,           // read strobe
    output logic      [31:0] reg_rdata,        // read data, next cycle
    output logic             redirect,         // fetch redirect pulse
    output logic      [31:0] redirect_addr,    // vector fetch address
    output logic             kill_insn,        // squash faulting insn
    output logic             hold_base_update  // keep update base register
);
    import pdxe_pkg::*;

    logic [31:0] spc_r;
    logic [31:0] sms_r;
    logic [31:0] dfs_r;
    logic [31:0] dfa_r;
    logic [31:0] brka_r;
    logic [31:0] msr_r;
    logic [31:0] vec_r;
    logic [1:0]  cfg_r;
    logic [31:0] rdata_r;
    logic        redirect_r;
    logic        kill_r;
    logic        hold_r;
    logic [31:0] raddr_r;
    // next values, chosen by the continuous selects further down
    logic [31:0] spc_upd_nxt;
    logic [31:0] sms_upd_nxt;
    logic [31:0] dfs_upd_nxt;
    logic [31:0] dfa_upd_nxt;
    logic [31:0] brka_upd_nxt;
    logic [31:0] msr_upd_nxt;
    logic [31:0] vec_upd_nxt;
    logic [1:0]  cfg_upd_nxt;
    logic [31:0] rdata_upd_nxt;
    logic        redirect_upd_nxt;
    logic        kill_upd_nxt;
    logic        hold_upd_nxt;
    logic [31:0] raddr_upd_nxt;

    // sources, priority: debug port nmi, fetch, data, breakpoints, port requests, emulation
    wire fetch_prot_on = msr_r[MSR_IR_POS];
    wire data_prot_on  = msr_r[MSR_DR_POS];
    wire dcmp_on       = msr_r[MSR_DCMP_POS];
    wire ifault = fetch_valid & fetch_prot_on
                & (fetch_refused | fetch_guarded);
    wire dfault = data_valid & data_prot_on & data_refused;
    wire dev_any = devport_req | periph_brk;
    // alignment faults are dropped before execution, never vectored here
    wire unimpl_ok = unimpl_insn & ~align_fault;

    wire take_nmi  = devport_nmi;
    wire take_if   = ~take_nmi & ifault;
    wire take_df   = ~take_nmi & ~take_if & dfault;
    wire take_ib   = ~take_nmi & ~take_if & ~take_df & ibrk_match;
    wire take_lb   = ~take_nmi & ~take_if & ~take_df & ~take_ib & lbrk_match;
    wire take_dev  = ~take_nmi & ~take_if & ~take_df & ~take_ib & ~take_lb
                   & dev_any;
    wire take_emu  = ~take_nmi & ~take_if & ~take_df & ~take_ib & ~take_lb
                   & ~take_dev & unimpl_ok;
    wire take_dbg  = take_nmi | take_ib | take_lb | take_dev;
    wire take_any  = take_if | take_df | take_dbg | take_emu;

    // vector offset by cause
    wire [31:0] vec_off =
        take_nmi ? VEC_DEV_NMI :
        take_if  ? VEC_IPROT   :
        take_df  ? VEC_DPROT   :
        take_ib  ? VEC_IBRK    :
        take_lb  ? VEC_DBRK    :
        take_dev ? VEC_DEV_MASK:
                   VEC_EMUL;
    wire [31:0] vec_base = msr_r[MSR_IP_POS] ? VEC_BASE_HI : VEC_BASE_LO;
    wire [31:0] vec_addr = vec_base | vec_off;

    // saved pc: in decompress mode insn_pc already carries the compressed
    // address, and for fetch faults there any value is allowed
    wire [31:0] spc_nxt =
        take_if  ? fetch_pc :
        take_df  ? insn_pc  :
        take_ib  ? insn_pc  :
        take_lb  ? next_pc  :
        take_emu ? insn_pc  :
                   next_pc;

    // saved state: low half from machine state, bit 30 copied not cleared
    wire [31:0] msr_low = msr_r & SMS_LOW_MASK;
    wire [31:0] sms_if  = msr_low
                        | ({31'h0, fetch_guarded} << SMS_GUARD_POS)
                        | ({31'h0, fetch_refused} << SMS_PROT_POS);
    // debug and emulation keep 0 and 5:9 from old saved state, 16:31 copied, rest cleared
    wire [31:0] sms_dbg = (sms_r & ~SMS_DBG_MASK) | msr_low;
    wire [31:0] sms_nxt =
        take_if ? sms_if :
        take_df ? msr_low :
                  sms_dbg;

    wire [31:0] dfs_nxt = ({31'h0, data_refused} << DFS_PROT_POS)
                        | ({31'h0, data_store} << DFS_STORE_POS);

    // new machine state on entry
    wire dcmp_new = cfg_r[CFG_EN_COMP_POS] & cfg_r[CFG_EXCEPTION_COMPRESSION_POS];
    wire [31:0] msr_entry =
          ({31'h0, msr_r[MSR_IP_POS]}  << MSR_IP_POS)
        | ({31'h0, msr_r[MSR_ME_POS]}  << MSR_ME_POS)
        // exception endian bit itself is cleared, only copied into endian
        | ({31'h0, msr_r[MSR_ILE_POS]} << MSR_LE_POS)
        | ({31'h0, dcmp_new}           << MSR_DCMP_POS);

    wire wr_spc  = reg_wr & (reg_addr == REG_SPC);
    wire wr_sms  = reg_wr & (reg_addr == REG_SMS);
    wire wr_dfs  = reg_wr & (reg_addr == REG_DFS);
    wire wr_dfa  = reg_wr & (reg_addr == REG_DFA);
    wire wr_brka = reg_wr & (reg_addr == REG_BRKA);
    wire wr_msr  = reg_wr & (reg_addr == REG_MSR);
    wire wr_cfg  = reg_wr & (reg_addr == REG_CFG);

    wire [31:0] rd_mux =
        (reg_addr == REG_SPC)  ? spc_r  :
        (reg_addr == REG_SMS)  ? sms_r  :
        (reg_addr == REG_DFS)  ? dfs_r  :
        (reg_addr == REG_DFA)  ? dfa_r  :
        (reg_addr == REG_BRKA) ? brka_r :
        (reg_addr == REG_MSR)  ? msr_r  :
        (reg_addr == REG_CFG)  ? {30'h0, cfg_r} :
        (reg_addr == REG_VEC)  ? vec_r  : 32'h00000000;

    // hardware entry wins over a software write in the same cycle,
    // so software cannot corrupt a save that is being made
    assign spc_upd_nxt =
        take_any ? spc_nxt   :
        wr_spc   ? reg_wdata :
                   spc_r;
    assign sms_upd_nxt =
        take_any ? sms_nxt   :
        wr_sms   ? reg_wdata :
                   sms_r;
    assign msr_upd_nxt =
        take_any ? msr_entry :
        wr_msr   ? reg_wdata :
                   msr_r;
    assign vec_upd_nxt =
        take_any ? vec_addr :
                   vec_r;
    // fault status and address move only on a data fault or a software write
    assign dfs_upd_nxt =
        take_df  ? dfs_nxt   :
        wr_dfs   ? reg_wdata :
                   dfs_r;
    assign dfa_upd_nxt =
        take_df  ? data_ea   :
        wr_dfa   ? reg_wdata :
                   dfa_r;
    assign brka_upd_nxt =
        take_lb  ? data_ea   :
        wr_brka  ? reg_wdata :
                   brka_r;
    assign cfg_upd_nxt =
        wr_cfg   ? reg_wdata[1:0] :
                   cfg_r;
    // read data stands one cycle only, zero otherwise
    assign rdata_upd_nxt =
        reg_rd   ? rd_mux :
                   32'h00000000;
    assign redirect_upd_nxt = take_any;
    // redirect address holds so the pipeline may sample it late
    assign raddr_upd_nxt =
        take_any ? vec_addr :
                   raddr_r;
    assign kill_upd_nxt = align_fault | take_if | take_emu;
    // partial multi-access store: base register left alone
    assign hold_upd_nxt = take_df & data_store & ~data_first;

    // one short register process per state element
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            spc_r <= 32'h00000000;
        end
        else
        begin
            spc_r <= spc_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sms_r <= 32'h00000000;
        end
        else
        begin
            sms_r <= sms_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            msr_r <= MSR_RESET;
        end
        else
        begin
            msr_r <= msr_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vec_r <= 32'h00000000;
        end
        else
        begin
            vec_r <= vec_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dfs_r <= 32'h00000000;
        end
        else
        begin
            dfs_r <= dfs_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dfa_r <= 32'h00000000;
        end
        else
        begin
            dfa_r <= dfa_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            brka_r <= 32'h00000000;
        end
        else
        begin
            brka_r <= brka_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_r <= 2'h0;
        end
        else
        begin
            cfg_r <= cfg_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_r <= 32'h00000000;
        end
        else
        begin
            rdata_r <= rdata_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            redirect_r <= 1'b0;
        end
        else
        begin
            redirect_r <= redirect_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            raddr_r <= 32'h00000000;
        end
        else
        begin
            raddr_r <= raddr_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            kill_r <= 1'b0;
        end
        else
        begin
            kill_r <= kill_upd_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_r <= 1'b0;
        end
        else
        begin
            hold_r <= hold_upd_nxt;
        end
    end

    assign reg_rdata        = rdata_r;
    assign redirect         = redirect_r;
    assign redirect_addr    = raddr_r;
    assign kill_insn        = kill_r;
    assign hold_base_update = hold_r;
    // unused bit kept for visibility of decompress mode at entry
    wire unused_dcmp = dcmp_on;
endmodule : pdxe_entry

// ==== tb/pdxe_entry_chk.sv ====
// port-level assertions for the exception entry unit
`timescale 1ns/10ps
module pdxe_entry_chk
(
    input wire logic clk, resetn, fetch_valid, data_valid, data_store,
    input wire logic data_first, ibrk_match, lbrk_match, periph_brk,
    input wire logic devport_req, devport_nmi, unimpl_insn, align_fault,
    input wire logic redirect, kill_insn, hold_base_update,
    input wire logic [31:0] redirect_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // no higher priority source present
    wire q = !(fetch_valid | data_valid | devport_nmi | ibrk_match
        | lbrk_match | periph_brk | devport_req);
    wire any = !q | unimpl_insn;
    a_nmi_vector: assert property (devport_nmi |=> redirect
        && redirect_addr[15:0] == 16'h1f00) else $error("nmi vector");
    a_ibrk_vector: assert property (ibrk_match && !fetch_valid
        && !data_valid && !devport_nmi
        |=> redirect && redirect_addr[15:0] == 16'h1d00)
        else $error("ibrk vector");
    a_emul_vector: assert property (unimpl_insn && q && !align_fault
        |=> redirect && redirect_addr[15:0] == 16'h1000)
        else $error("emulation vector");
    a_align_kill: assert property (align_fault && q && !unimpl_insn
        |=> kill_insn && !redirect) else $error("alignment kill");
    a_hold_store: assert property (hold_base_update |-> redirect
        && redirect_addr[15:0] == 16'h1400
        && $past(data_store && !data_first)) else $error("base hold");
    a_vec_base: assert property (redirect |->
        redirect_addr[31:20] == 12'h000 || redirect_addr[31:20] == 12'hfff)
        else $error("vector base");
    a_redir_cause: assert property (redirect |-> $past(any))
        else $error("redirect without cause");
    a_kill_cause: assert property (kill_insn
        |-> $past(align_fault | fetch_valid | unimpl_insn))
        else $error("kill without cause");
endmodule : pdxe_entry_chk
bind pdxe_entry pdxe_entry_chk chk_u (.*);

// ==== tb/pdxe_pipe_model.sv ====
// pipeline stand-in supplying instruction addresses to the entry unit
`timescale 1ns/10ps
module pdxe_pipe_model
(
    clk,           // core clock
    resetn,        // async reset, active low
    redirect,      // vector fetch pulse
    redirect_addr, // vector address
    insn_pc,       // current instruction
    next_pc        // following instruction
);
    input  wire logic        clk;
    input  wire logic        resetn;
    input  wire logic        redirect;
    input  wire logic [31:0] redirect_addr;
    output logic      [31:0] insn_pc;
    output logic      [31:0] next_pc;
    // holds still between exceptions so the bench can predict saved pcs
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            insn_pc <= 32'h00002000;
        else if (redirect)
            insn_pc <= redirect_addr;
    assign next_pc = insn_pc + 32'h00000004;
endmodule : pdxe_pipe_model

// ==== tb/tb.sv ====
// self-checking bench for the exception entry unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
    import pdxe_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic fetch_valid = 0, fetch_refused = 0, fetch_guarded = 0;
    logic data_valid = 0, data_refused = 0, data_store = 0, data_first = 0;
    logic ibrk_match = 0, lbrk_match = 0, periph_brk = 0, devport_req = 0;
    logic devport_nmi = 0, unimpl_insn = 0, align_fault = 0;
    logic [31:0] fetch_pc = 0, data_ea = 0, reg_wdata = 0;
    logic [3:0]  reg_addr = 0;
    wire  [31:0] insn_pc, next_pc, reg_rdata, redirect_addr;
    wire         redirect, kill_insn, hold_base_update;
    int          num_errors = 0, checks = 0;
    logic [31:0] d, pc, npc;
    logic [31:0] vt [6] = '{VEC_IBRK, VEC_DBRK, VEC_DEV_MASK, VEC_DEV_MASK,
        VEC_DEV_NMI, VEC_EMUL};
    always #12.5 clk = ~clk;
    pdxe_entry dut_u (.*);
    pdxe_pipe_model pipe_u (.*);
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // sources were raised at the previous edge; drop them, judge redirect
    task go(input string n, input logic r, input logic [31:0] v);
        @(posedge clk);
        {fetch_valid, fetch_refused, fetch_guarded, data_valid} <= 4'h0;
        {data_refused, data_store, ibrk_match, lbrk_match} <= 4'h0;
        {periph_brk, devport_req, devport_nmi, unimpl_insn} <= 4'h0;
        align_fault <= 1'b0;
        #1 `CHK(n, r, redirect)
        if (r) `CHK(n, v, redirect_addr)
    endtask : go
    task t_fetch;
        wr(REG_CFG, 32'h3); wr(REG_MSR, 32'h00019060);
        @(posedge clk); pc = insn_pc; fetch_valid <= 1; fetch_refused <= 1;
        fetch_pc <= pc;
        go("ifault vec", 1'b1, VEC_BASE_HI | VEC_IPROT);
        rd(REG_SPC); `CHK("ifault spc", pc, d)
        rd(REG_SMS); `CHK("ifault sms", 32'h08009060, d)
        rd(REG_MSR); `CHK("ifault msr", 32'h00001441, d)
        wr(REG_MSR, 32'h00000020);
        @(posedge clk); fetch_valid <= 1; fetch_guarded <= 1;
        go("guard vec", 1'b1, VEC_IPROT);
        rd(REG_SMS); `CHK("guard sms", 32'h10000020, d)
        @(posedge clk); fetch_valid <= 1; fetch_refused <= 1;
        go("ifault off", 1'b0, 0);
        $display("test fetch done");
    endtask : t_fetch
    task t_data;
        wr(REG_MSR, 32'h00019072);
        @(posedge clk); pc = insn_pc; data_valid <= 1; data_refused <= 1;
        data_store <= 1; data_first <= 0; data_ea <= 32'habcd0010;
        go("dfault vec", 1'b1, VEC_BASE_HI | VEC_DPROT);
        `CHK("base hold", 1'b1, hold_base_update)
        rd(REG_SPC); `CHK("dfault spc", pc, d)
        rd(REG_DFS); `CHK("dfault dfs", 32'h0a000000, d)
        rd(REG_DFA); `CHK("dfault dfa", 32'habcd0010, d)
        rd(REG_SMS); `CHK("dfault sms", 32'h00009072, d)
        @(posedge clk); data_valid <= 1; data_refused <= 1;
        go("dfault off", 1'b0, 0);
        $display("test data done");
    endtask : t_data
    task t_debug;
        for (int i = 0; i < 6; i++)
        begin
            wr(REG_MSR, 32'h00000003);
            @(posedge clk); pc = insn_pc; npc = next_pc;
            data_ea <= 32'h0000a000 + i;
            case (i)
                0: ibrk_match <= 1'b1;
                1: lbrk_match <= 1'b1;
                2: periph_brk <= 1'b1;
                3: devport_req <= 1'b1;
                4: devport_nmi <= 1'b1;
                default: unimpl_insn <= 1'b1;
            endcase
            go("dbg vec", 1'b1, vt[i]);
            rd(REG_SPC); `CHK("dbg spc", (i == 0 || i == 5) ? pc : npc, d)
            rd(REG_SMS); `CHK("dbg sms", 32'h3, d & 32'h783fffff)
        end
        rd(REG_BRKA); `CHK("brk addr", 32'h0000a001, d)
        $display("test debug done");
    endtask : t_debug
    task t_misc;
        for (int i = 0; i < 9; i++)
        begin
            rd(i[3:0]); `CHK("reset value", 32'h0, d)
        end
        wr(4'h9, 32'hffffffff); rd(4'h9); `CHK("unmapped", 32'h0, d)
        @(posedge clk); align_fault <= 1'b1;
        go("align", 1'b0, 0); `CHK("align kill", 1'b1, kill_insn)
        wr(REG_MSR, 32'h00000020);
        @(posedge clk); fetch_valid <= 1; fetch_refused <= 1; devport_nmi <= 1;
        go("priority", 1'b1, VEC_DEV_NMI);
        $display("test misc done");
    endtask : t_misc
    task finish_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        #(4000 * 25);
        num_errors++;
        finish_test;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_misc; t_fetch; t_data; t_debug;
        finish_test;
    end
endmodule : tb
